// [inc/plc_pkg.sv]
// Package of constants and types for the port link control and status block.
// Operation
// - Hold local response credit size, default 5.
// - Hold local request credit size, default 5.
// - Retry-disable bit turns off link retry.
// - Retry always off during framing and initialization.
// - Capture partner response credit size from idles.
// - Capture partner request credit size from idles.
// - Port disabled tristates outputs except sync.
// - Disabling drops sync and restarts initialization.
// - Enabled drives outputs; data waits for framing.
// - Set idle-ack bit; clear at init start.
// - Set idle bit after 256 valid idles.
// - Interrupt on idle-detected rising when enabled.
// - Idle transition detector reset at init start.
// - Clearing an enable withdraws its request.
// - Present bit follows pin; absent tristates, reroutes to the other port or aborts.
// - Interrupt on any present change when enabled.
// - Redirect to other port; none enabled aborts.
package plc_pkg;
	// ==========================================
	// Register map
	localparam logic [7:0] PLC_CTRL_OFF = 8'hc0;
	localparam int RSP_CR_LSB = 16;
	localparam int REQ_CR_LSB = 13;
	localparam int RETRY_DIS_BIT = 12;
	localparam int PRSP_CR_LSB = 9;
	localparam int PREQ_CR_LSB = 6;
	localparam int PORT_EN_BIT = 5;
	localparam int ACK_DET_BIT = 4;
	localparam int IDLE_DET_BIT = 3;
	localparam int IDLE_IE_BIT = 2;
	localparam int PRES_BIT = 1;
	localparam int PRES_IE_BIT = 0;
	localparam logic [2:0] CREDIT_SIZE_RST = 3'h5;
	localparam logic [2:0] CREDIT_CAP_SIZE = 3'h5;
	localparam logic [5:0] CREDIT_CAP = 6'h19;
	localparam logic [8:0] IDLE_RUN_COUNT = 9'h100;
	localparam logic [3:0] INIT_CYCLES = 4'h8;

	// ==========================================
	// Types
	typedef enum logic [1:0] {
		PLC_ST_DOWN  = 2'b00,
		PLC_ST_INIT  = 2'b01,
		PLC_ST_FRAME = 2'b10,
		PLC_ST_RUN   = 2'b11
	} plc_state_t;

	typedef struct packed {
		logic       idle_valid;
		logic       idle_ack;
		logic [2:0] rsp_size;
		logic [2:0] req_size;
	} plc_idle_t;
endpackage

// [hw/plc_top.sv]
// Control and status logic for one scale_port link.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module plc_top (
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              link_clk,
	input  wire plc_pkg::plc_idle_t rx_idle,
	input  wire logic              port_present_pin,
	input  wire logic              firmware_enable_strap,
	input  wire logic              processor_present_strap,
	input  wire logic              other_port_enabled,
	output logic                   link_sync_output,
	output logic                   port_out_oe_n,
	output logic                   link_level_retry,
	output logic                   data_xfer_ok,
	output logic [2:0]             tx_rsp_size,
	output logic [2:0]             tx_req_size,
	output logic [4:0]             tx_rsp_credits,
	output logic [4:0]             tx_req_credits,
	output logic                   route_here,
	output logic                   route_other,
	output logic                   route_abort,
	output logic                   int_out_o,
	output logic                   int_out_oe_n
);
	// ==========================================
	// Pin synchronisers
	logic [2:0] lclk_s_q, pres_s_q, val_s_q, ack_s_q;
	logic [2:0] rsp_s1_q, rsp_s2_q, req_s1_q, req_s2_q;
	logic       lclk_st_q, pres_st_q, vs_q, as_q;
	logic [2:0] rsp_st_q, req_st_q;
	logic       straps_done_q;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			lclk_s_q <= 3'h0;
			pres_s_q <= 3'h0;
			val_s_q  <= 3'h0;
			ack_s_q  <= 3'h0;
			rsp_s1_q <= 3'h0;
			rsp_s2_q <= 3'h0;
			req_s1_q <= 3'h0;
			req_s2_q <= 3'h0;
		end else begin
			lclk_s_q <= {lclk_s_q[1:0], link_clk};
			pres_s_q <= {pres_s_q[1:0], port_present_pin};
			val_s_q  <= {val_s_q[1:0], rx_idle.idle_valid};
			ack_s_q  <= {ack_s_q[1:0], rx_idle.idle_ack};
			rsp_s1_q <= rx_idle.rsp_size;
			rsp_s2_q <= rsp_s1_q;
			req_s1_q <= rx_idle.req_size;
			req_s2_q <= req_s1_q;
		end
	end
	// A change on a single-bit pin is accepted only when the second and third stages agree; the size fields pass through unchecked.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			lclk_st_q <= 1'b0;
			pres_st_q <= 1'b0;
			vs_q      <= 1'b0;
			as_q      <= 1'b0;
			rsp_st_q  <= 3'h0;
			req_st_q  <= 3'h0;
		end else begin
			if (lclk_s_q[1] == lclk_s_q[2]) lclk_st_q <= lclk_s_q[2];
			if (pres_s_q[1] == pres_s_q[2]) pres_st_q <= pres_s_q[2];
			if (val_s_q[1] == val_s_q[2]) vs_q <= val_s_q[2];
			if (ack_s_q[1] == ack_s_q[2]) as_q <= ack_s_q[2];
			rsp_st_q <= rsp_s2_q;
			req_st_q <= req_s2_q;
		end
	end
	logic lclk_d1_q;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) lclk_d1_q <= 1'b0;
		else lclk_d1_q <= lclk_st_q;
	end
	wire lclk_rise = lclk_st_q & ~lclk_d1_q;

	// ==========================================
	// Register fields
	logic [2:0] rsp_cr_q, req_cr_q, prsp_q, preq_q;
	logic       retry_dis_q, port_en_q, ack_det_q, idle_det_q;
	logic       idle_ie_q, pres_ie_q, idle_irq_q, pres_irq_q, pres_d1_q;
	plc_pkg::plc_state_t st_q, st_d;
	logic [3:0] init_cnt_q;
	logic [8:0] run_cnt_q;

	// ==========================================
	// Bus slave
	logic        ap_wr_q, ap_sel_q;
	wire         ap_valid = hsel & htrans[1] & hready;
	wire         addr_hit = (haddr[7:0] == plc_pkg::PLC_CTRL_OFF) && (haddr[31:8] == 24'h0);
	wire         wr_strobe = ap_wr_q & ap_sel_q;
	wire [31:0]  reg_view = {13'h0,
		rsp_cr_q, req_cr_q, retry_dis_q, prsp_q, preq_q,
		port_en_q, ack_det_q, idle_det_q, idle_ie_q, pres_st_q, pres_ie_q};
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ap_wr_q <= 1'b0;
			ap_sel_q <= 1'b0;
			hrdata <= 32'h0;
		end else begin
			ap_wr_q  <= ap_valid & hwrite;
			ap_sel_q <= ap_valid & addr_hit;
			hrdata   <= (ap_valid & ~hwrite & addr_hit) ? reg_view : 32'h0;
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ==========================================
	// Link sequencing
	wire init_start = (st_q == plc_pkg::PLC_ST_DOWN) & port_en_q & pres_st_q;
	wire frame_start = (st_q == plc_pkg::PLC_ST_INIT) & (init_cnt_q == plc_pkg::INIT_CYCLES);
	wire port_live = port_en_q & pres_st_q;
	always_comb begin
		st_d = st_q;
		case (st_q)
			plc_pkg::PLC_ST_DOWN:  if (port_live) st_d = plc_pkg::PLC_ST_INIT;
			plc_pkg::PLC_ST_INIT:  if (frame_start) st_d = plc_pkg::PLC_ST_FRAME;
			plc_pkg::PLC_ST_FRAME: if (idle_det_q) st_d = plc_pkg::PLC_ST_RUN;
			plc_pkg::PLC_ST_RUN:   st_d = plc_pkg::PLC_ST_RUN;
			default:               st_d = plc_pkg::PLC_ST_DOWN;
		endcase
		if (!port_live) st_d = plc_pkg::PLC_ST_DOWN;
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_q <= plc_pkg::PLC_ST_DOWN;
			init_cnt_q <= 4'h0;
		end else begin
			st_q <= st_d;
			if (st_q != plc_pkg::PLC_ST_INIT) init_cnt_q <= 4'h0;
			else if (lclk_rise) init_cnt_q <= init_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) run_cnt_q <= 9'h0;
		else if (st_q != plc_pkg::PLC_ST_FRAME || (lclk_rise && !vs_q)) run_cnt_q <= 9'h0;
		else if (lclk_rise && run_cnt_q != plc_pkg::IDLE_RUN_COUNT) run_cnt_q <= run_cnt_q + 9'h1;
	end

	// ==========================================
	// Fields and events
	wire idle_rise = (st_q == plc_pkg::PLC_ST_FRAME) & ~idle_det_q &
		(run_cnt_q == plc_pkg::IDLE_RUN_COUNT);
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rsp_cr_q <= plc_pkg::CREDIT_SIZE_RST;
			req_cr_q <= plc_pkg::CREDIT_SIZE_RST;
			retry_dis_q <= 1'b0;
			port_en_q <= 1'b0;
			idle_ie_q <= 1'b0;
			pres_ie_q <= 1'b0;
		end else if (!straps_done_q) begin
			port_en_q <= ~firmware_enable_strap | ~processor_present_strap;
		end else if (wr_strobe) begin
			rsp_cr_q <= hwdata[plc_pkg::RSP_CR_LSB +: 3];
			req_cr_q <= hwdata[plc_pkg::REQ_CR_LSB +: 3];
			retry_dis_q <= hwdata[plc_pkg::RETRY_DIS_BIT];
			port_en_q <= hwdata[plc_pkg::PORT_EN_BIT];
			idle_ie_q <= hwdata[plc_pkg::IDLE_IE_BIT];
			pres_ie_q <= hwdata[plc_pkg::PRES_IE_BIT];
		end
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			straps_done_q <= 1'b0;
			prsp_q <= 3'h0;
			preq_q <= 3'h0;
			ack_det_q <= 1'b0;
			idle_det_q <= 1'b0;
			pres_d1_q <= 1'b0;
		end else begin
			straps_done_q <= 1'b1;
			pres_d1_q <= pres_st_q;
			if (lclk_rise && vs_q) begin
				prsp_q <= rsp_st_q;
				preq_q <= req_st_q;
			end
			// ack seen, cleared at init
			// A valid idle that lands on the init start still counts, so the set wins.
			if (lclk_rise && vs_q && as_q) ack_det_q <= 1'b1;
			else if (init_start) ack_det_q <= 1'b0;
			if (init_start) idle_det_q <= 1'b0;
			else if (idle_rise) idle_det_q <= 1'b1;
		end
	end
	wire idle_ie_n = wr_strobe ? hwdata[plc_pkg::IDLE_IE_BIT] : idle_ie_q;
	wire pres_ie_n = wr_strobe ? hwdata[plc_pkg::PRES_IE_BIT] : pres_ie_q;
	wire idle_clr  = wr_strobe & ~hwdata[plc_pkg::IDLE_IE_BIT];
	wire pres_clr  = wr_strobe & ~hwdata[plc_pkg::PRES_IE_BIT];
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			idle_irq_q <= 1'b0;
			pres_irq_q <= 1'b0;
		end else begin
			if (idle_rise && idle_ie_n) idle_irq_q <= 1'b1;
			else if (idle_clr) idle_irq_q <= 1'b0;
			if ((pres_st_q != pres_d1_q) && pres_ie_n) pres_irq_q <= 1'b1;
			else if (pres_clr) pres_irq_q <= 1'b0;
		end
	end

	// ==========================================
	// Outputs
	function automatic logic [4:0] credits(input logic [2:0] sz);
		credits = (sz >= plc_pkg::CREDIT_CAP_SIZE) ? plc_pkg::CREDIT_CAP[4:0] : 5'(5'h1 << sz);
	endfunction
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			link_sync_output <= 1'b0;
			port_out_oe_n <= 1'b1;
			link_level_retry <= 1'b0;
			data_xfer_ok <= 1'b0;
			tx_rsp_size <= plc_pkg::CREDIT_SIZE_RST;
			tx_req_size <= plc_pkg::CREDIT_SIZE_RST;
			tx_rsp_credits <= plc_pkg::CREDIT_CAP[4:0];
			tx_req_credits <= plc_pkg::CREDIT_CAP[4:0];
			route_here <= 1'b0;
			route_other <= 1'b0;
			route_abort <= 1'b1;
			int_out_o <= 1'b0;
			int_out_oe_n <= 1'b1;
		end else begin
			link_sync_output <= port_live;
			port_out_oe_n <= ~port_live;
			// retry only after framing
			// Gating by port_live keeps data off in the cycle the drivers are released.
			link_level_retry <= (st_q == plc_pkg::PLC_ST_RUN) & port_live & ~retry_dis_q;
			data_xfer_ok <= (st_q == plc_pkg::PLC_ST_RUN) & port_live;
			tx_rsp_size <= rsp_cr_q;
			tx_req_size <= req_cr_q;
			tx_rsp_credits <= credits(rsp_cr_q);
			tx_req_credits <= credits(req_cr_q);
			route_here <= port_live;
			route_other <= ~port_live & other_port_enabled;
			route_abort <= ~port_live & ~other_port_enabled;
			// open drain pin low while pending
			int_out_o <= 1'b0;
			int_out_oe_n <= ~(idle_irq_q | pres_irq_q);
		end
	end
endmodule

// [bench/plc_checker.sv]
// Checker of the port link control block at its top ports.
`timescale 1ns/1ps
module plc_checker (
	input wire logic	sys_clk,
	input wire logic	reset,
	input wire logic	hsel,
	input wire logic [31:0]	haddr,
	input wire logic [1:0]	htrans,
	input wire logic	hwrite,
	input wire logic	hready,
	input wire logic [31:0]	hwdata,
	input wire logic	link_sync_output,
	input wire logic	port_out_oe_n,
	input wire logic	link_level_retry,
	input wire logic	data_xfer_ok,
	input wire logic [2:0]	tx_rsp_size,
	input wire logic [4:0]	tx_rsp_credits,
	input wire logic	route_here,
	input wire logic	route_other,
	input wire logic	route_abort,
	input wire logic	int_out_oe_n
);
	// ======
	// Properties
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_wr;
		hsel && htrans[1] && hready && hwrite && haddr == 32'h0000_00c0;
	endsequence
	a_sync_drop: assert property (s_wr ##1 !hwdata[5] |-> ##[1:3] !link_sync_output)
		else $error("sync still high after disable");
	a_retry_off: assert property (s_wr ##1 hwdata[12] |-> ##[1:3] !link_level_retry)
		else $error("retry still on after disable");
	a_irq_drop: assert property (s_wr ##1 !hwdata[2] && !hwdata[0] |-> ##[1:3] int_out_oe_n)
		else $error("interrupt pin still pulled");
	a_retry_run: assert property (link_level_retry |-> data_xfer_ok)
		else $error("retry active before framing done");
	a_drive_run: assert property (data_xfer_ok |-> !port_out_oe_n)
		else $error("transfer allowed with drivers off");
	a_off_float: assert property ($fell(link_sync_output) |-> ##[0:2] port_out_oe_n)
		else $error("outputs driven while port off");
	a_rsp_cap: assert property (tx_rsp_credits ==
		(tx_rsp_size >= 3'h5 ? 5'h19 : 5'h01 << tx_rsp_size))
		else $error("response credit decode wrong");
	a_route_one: assert property ($onehot({route_here, route_other, route_abort}))
		else $error("routing not one-hot");
endmodule

bind plc_top plc_checker i_chk (.sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hwdata, .link_sync_output, .port_out_oe_n, .link_level_retry, .data_xfer_ok,
	.tx_rsp_size, .tx_rsp_credits, .route_here, .route_other, .route_abort, .int_out_oe_n);

// [bench/plc_partner.sv]
// Behavioural peer that sends idle flits over the link.
`timescale 1ns/1ps
module plc_partner (
	input wire logic	run,
	input wire logic	ack,
	input wire logic [2:0]	rsp,
	input wire logic [2:0]	req,
	output logic	link_clk,
	output plc_pkg::plc_idle_t	rx_idle
);
	// ======
	// Link
	// The link clock stands still between frames, and stale fields are scrambled then.
	initial begin
		link_clk = 1'b0;
		rx_idle = '0;
		forever begin
			#80;
			if (run) begin
				link_clk = ~link_clk;
				if (!link_clk) rx_idle = '{1'b1, ack, rsp, req};
			end else begin
				link_clk = 1'b0;
				rx_idle = '{1'b0, ~rx_idle.idle_ack, ~rx_idle.rsp_size, ~rx_idle.req_size};
			end
		end
	end
endmodule

// [bench/port_link_control_status_tb.sv]
// Self-checking bench for the port link control block.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
	$display("Error %0t: got %h expected %h", $time, a, e); end end
module port_link_control_status_tb;
	logic	sys_clk, reset, hsel, hwrite, run, pres, other, hreadyout, hresp, fw;
	logic [31:0]	haddr, hwdata, hrdata, rq;
	logic [1:0]	htrans;
	logic	link_clk, sync, oe_n, retry, xfer, r_here, r_other, r_abort, int_o, int_oe_n;
	logic [2:0]	tx_rsp, tx_req;
	logic [4:0]	cr_rsp, cr_req;
	plc_pkg::plc_idle_t	rx_idle;
	int	bad_count, checked;

	plc_top i_dut (.sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .link_clk, .rx_idle,
		.port_present_pin(pres), .firmware_enable_strap(fw),
		.processor_present_strap(1'b1), .other_port_enabled(other),
		.link_sync_output(sync), .port_out_oe_n(oe_n), .link_level_retry(retry),
		.data_xfer_ok(xfer), .tx_rsp_size(tx_rsp), .tx_req_size(tx_req),
		.tx_rsp_credits(cr_rsp), .tx_req_credits(cr_req), .route_here(r_here),
		.route_other(r_other), .route_abort(r_abort), .int_out_o(int_o),
		.int_out_oe_n(int_oe_n));
	plc_partner i_peer (.run, .ack(1'b1), .rsp(3'h5), .req(3'h2), .link_clk, .rx_idle);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ======
	// Tasks
	task automatic report_and_stop;
		$display("Compared %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic fail_out;
		bad_count++;
		$display("Error %0t: wait timed out", $time);
		report_and_stop;
	endtask
	task automatic hwait;
		for (int n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (hreadyout === 1'b1) return;
		end
		fail_out;
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hwait;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hwait;
		rq = hrdata;
	endtask

	// ======
	// Scenarios
	initial begin
		{hsel, hwrite, run, haddr, hwdata, htrans} = '0;
		{fw, pres, other, reset} = 4'hf;
		bad_count = 0;
		checked = 0;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (6) @(posedge sys_clk);
		bus(1'b0, 32'h0000_00c0, 32'h0);
		`CHK(rq, 32'h0005_a002)
		`CHK({oe_n, sync, r_other}, 3'b101)
		`CHK({cr_rsp, cr_req}, 10'h339)
		bus(1'b0, 32'h0000_00c4, 32'h0);
		`CHK(rq, 32'h0)
		bus(1'b1, 32'h0000_00c0, 32'h0003_4025);
		repeat (4) @(posedge sys_clk);
		`CHK({cr_rsp, cr_req}, 10'h104)
		`CHK({tx_rsp, tx_req}, 6'h1a)
		`CHK({oe_n, sync, r_here}, 3'b011)
		`CHK(retry, 1'b0)
		run <= 1'b1;
		for (int i = 0; i < 9000 && xfer !== 1'b1; i++) @(posedge sys_clk);
		if (xfer !== 1'b1) fail_out;
		repeat (4) @(posedge sys_clk);
		`CHK(retry, 1'b1)
		`CHK(int_oe_n, 1'b0)
		bus(1'b0, 32'h0000_00c0, 32'h0);
		`CHK(rq, 32'h0003_4abf)
		`CHK(rq[11:6], 6'h2a)
		`CHK(rq[4], 1'b1)
		bus(1'b1, 32'h0000_00c0, 32'h0003_5025);
		repeat (4) @(posedge sys_clk);
		`CHK(retry, 1'b0)
		`CHK(int_oe_n, 1'b0)
		bus(1'b1, 32'h0000_00c0, 32'h0003_5020);
		repeat (4) @(posedge sys_clk);
		`CHK(int_oe_n, 1'b1)
		bus(1'b1, 32'h0000_00c0, 32'h0003_5021);
		run <= 1'b0;
		pres <= 1'b0;
		repeat (12) @(posedge sys_clk);
		`CHK(int_oe_n, 1'b0)
		`CHK({oe_n, sync}, 2'b10)
		`CHK({int_o, hresp}, 2'b00)
		bus(1'b0, 32'h0000_00c0, 32'h0);
		`CHK(rq[1], 1'b0)
		pres <= 1'b1;
		repeat (12) @(posedge sys_clk);
		bus(1'b1, 32'h0000_00c0, 32'h0003_5000);
		repeat (4) @(posedge sys_clk);
		`CHK({oe_n, sync}, 2'b10)
		`CHK(r_other, 1'b1)
		other <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK(r_abort, 1'b1)
		bus(1'b1, 32'h0000_00c0, 32'h0003_5020);
		repeat (4) @(posedge sys_clk);
		bus(1'b0, 32'h0000_00c0, 32'h0);
		`CHK(rq[4:3], 2'b00)
		`CHK(rq[11:6], 6'h2a)
		fw <= 1'b0;
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (8) @(posedge sys_clk);
		bus(1'b0, 32'h0000_00c0, 32'h0);
		`CHK({rq[5], rq[4:3], oe_n}, 4'b1000)
		report_and_stop;
	end
endmodule
